// ===== common/pic_pkg.sv
// constants, types and register map of the priority interrupt controller
`default_nettype none
package pic_pkg;
    localparam int PIC_NSRC = 16;
    localparam logic [7:0] PIC_OFF_SWP0 = 8'h25;
    localparam logic [7:0] PIC_OFF_SWP1 = 8'h26;
    localparam logic [7:0] PIC_OFF_SWP2 = 8'h27;
    localparam logic [7:0] PIC_OFF_SWP3 = 8'h28;
    localparam logic [7:0] PIC_OFF_EIC0 = 8'h29;
    localparam logic [7:0] PIC_OFF_EIC1 = 8'h2a;
    localparam logic [7:0] PIC_RST_SWP = 8'hff;
    localparam logic [7:0] PIC_RST_EIC = 8'h00;
    localparam logic [1:0] PIC_LVL_TOP = 2'h3;
    localparam logic [4:0] PIC_SRC_RESET = 5'h00;
    localparam logic [4:0] PIC_SRC_TRAP = 5'h01;
    localparam logic [4:0] PIC_SRC_TLI = 5'h02;
    localparam logic [4:0] PIC_SRC_MASK0 = 5'h03;
    localparam logic [2:0] PIC_STACK_BYTES = 3'h5;
    localparam logic [7:0] PIC_CC_RESET = 8'h28;
    localparam int PIC_CC_I1 = 5;
    localparam int PIC_CC_I0 = 3;

    typedef enum logic [3:0] {
        PIC_IDLE = 4'b0001,
        PIC_STACK = 4'b0010,
        PIC_VECT = 4'b0100,
        PIC_RUN = 4'b1000
    } pic_state_e;

    typedef struct packed {
        logic valid;
        logic [4:0] src;
        logic [1:0] lvl;
    } pic_win_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pic_bus_s;
endpackage : pic_pkg
`default_nettype wire

// ===== src/pic_interrupt_arbiter.sv
// interrupt arbiter: latching, two-step priority selection and entry sequence
`default_nettype none
module pic_interrupt_arbiter
    import pic_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // sources
    input wire logic trap_exec,
    input wire logic tli_pin,
    input wire logic [3:0] ext_pin,
    input wire logic [PIC_NSRC-1:4] periph_req,
    input wire logic [PIC_NSRC-1:4] periph_clear,
    input wire logic [PIC_NSRC-1:0] src_enable,
    // core side
    input wire logic core_halted,
    input wire logic iret_exec,
    input wire logic [7:0] stacked_cc,
    input wire logic [7:0] cc_in,
    output logic wake,
    output logic stack_push,
    output logic [2:0] stack_index,
    output logic vector_load,
    output logic [4:0] vector_src,
    output logic [7:0] cc_out,
    output logic cc_load,
    output logic [PIC_NSRC+2:0] pending
);
    pic_bus_s bus;
    pic_state_e state_ff, nxt_state;
    logic [7:0] swp_ff [4];
    logic [7:0] eic_ff [2];
    logic [7:0] reg_rdata_ff;
    logic tli_s1_ff, tli_s2_ff, tli_s3_ff;
    logic [3:0] ext_s1_ff, ext_s2_ff, ext_s3_ff;
    logic rst_pend_ff, trap_pend_ff, tli_pend_ff;
    logic [PIC_NSRC-1:0] mreq_ff;
    logic [1:0] cur_lvl;
    logic [2:0] stack_cnt_ff;
    pic_win_s win, win_ff;
    logic [7:0] cc_out_ff;
    logic cc_load_ff;
    logic in_trap_ff;
    logic [2:0] sync_fill_ff;
    logic sync_ok;
    logic take;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign cur_lvl = {cc_in[PIC_CC_I1], cc_in[PIC_CC_I0]};

    // two bits per maskable source; bits pattern 11 mirrors the top level
    function automatic logic [1:0] sw_level(input logic [7:0] r [4],
                                            input int idx);
        logic [7:0] b;
        b = r[idx / 4];
        sw_level = {b[(idx % 4) * 2 + 1], b[(idx % 4) * 2]};
    endfunction : sw_level

    // register file
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) swp_ff[i] <= PIC_RST_SWP;
            eic_ff[0] <= PIC_RST_EIC;
            eic_ff[1] <= PIC_RST_EIC;
        end else if (bus.wr) begin
            case (bus.addr)
                PIC_OFF_SWP0: swp_ff[0] <= bus.wdata;
                PIC_OFF_SWP1: swp_ff[1] <= bus.wdata;
                PIC_OFF_SWP2: swp_ff[2] <= bus.wdata;
                PIC_OFF_SWP3: swp_ff[3] <= bus.wdata;
                PIC_OFF_EIC0: eic_ff[0] <= bus.wdata;
                PIC_OFF_EIC1: eic_ff[1] <= bus.wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                PIC_OFF_SWP0: reg_rdata_ff <= swp_ff[0];
                PIC_OFF_SWP1: reg_rdata_ff <= swp_ff[1];
                PIC_OFF_SWP2: reg_rdata_ff <= swp_ff[2];
                PIC_OFF_SWP3: reg_rdata_ff <= swp_ff[3];
                PIC_OFF_EIC0: reg_rdata_ff <= eic_ff[0];
                PIC_OFF_EIC1: reg_rdata_ff <= eic_ff[1];
                default: reg_rdata_ff <= 8'h00;
            endcase
        end else begin
            reg_rdata_ff <= 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_ff;

    // pin synchronisers; third stage only feeds edge detection
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tli_s1_ff <= 1'b0;
            tli_s2_ff <= 1'b0;
            tli_s3_ff <= 1'b0;
            ext_s1_ff <= 4'h0;
            ext_s2_ff <= 4'h0;
            ext_s3_ff <= 4'h0;
        end else begin
            tli_s1_ff <= tli_pin;
            tli_s2_ff <= tli_s1_ff;
            tli_s3_ff <= tli_s2_ff;
            ext_s1_ff <= ext_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    logic entry;
    assign entry = (state_ff == PIC_VECT);

    // a new entry waits while a cc update is still on its way to the core,
    // else it would be judged against the mask level being replaced
    assign take = (state_ff == PIC_IDLE || state_ff == PIC_RUN) &&
                  win.valid && !cc_load_ff;

    // pin stages are trusted only once all three hold real samples, so a
    // pin already low or high at reset raises no false request
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_fill_ff <= 3'h0;
        end else begin
            sync_fill_ff <= {sync_fill_ff[1:0], 1'b1};
        end
    end
    assign sync_ok = sync_fill_ff[2];

    // non-maskable and top pin latches; set wins over clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rst_pend_ff <= 1'b1;
            trap_pend_ff <= 1'b0;
            tli_pend_ff <= 1'b0;
        end else begin
            if (entry && win_ff.src == PIC_SRC_RESET) rst_pend_ff <= 1'b0;
            if (trap_exec) begin
                trap_pend_ff <= 1'b1;
            end else if (entry && win_ff.src == PIC_SRC_TRAP) begin
                trap_pend_ff <= 1'b0;
            end
            if (sync_ok && tli_s2_ff && !tli_s3_ff) begin
                tli_pend_ff <= 1'b1;
            end else if (entry && win_ff.src == PIC_SRC_TLI) begin
                tli_pend_ff <= 1'b0;
            end
        end
    end

    // maskable request latches, generated per source
    genvar g;
    generate
        for (g = 0; g < PIC_NSRC; g++) begin : g_mreq
            logic set_req, clr_req;
            if (g < 4) begin : g_ext
                logic [1:0] sens;
                logic edge_hit;
                assign sens = {eic_ff[g / 2][(g % 2) * 2 + 1],
                               eic_ff[g / 2][(g % 2) * 2]};
                // 00 low level, 01 rising, 10 falling, 11 both edges
                always_comb begin
                    case (sens)
                        2'h0: edge_hit = !ext_s2_ff[g];
                        2'h1: edge_hit = ext_s2_ff[g] && !ext_s3_ff[g];
                        2'h2: edge_hit = !ext_s2_ff[g] && ext_s3_ff[g];
                        default: edge_hit = ext_s2_ff[g] ^ ext_s3_ff[g];
                    endcase
                end
                assign set_req = sync_ok && edge_hit;
                assign clr_req = 1'b0;
            end else begin : g_per
                assign set_req = periph_req[g];
                assign clr_req = periph_clear[g];
            end
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    mreq_ff[g] <= 1'b0;
                end else if (set_req) begin
                    mreq_ff[g] <= 1'b1;
                end else if (clr_req ||
                             (entry && win_ff.src ==
                              5'(g + PIC_SRC_MASK0))) begin
                    mreq_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // two-step selection; scan from lowest hardware rank so later wins
    always_comb begin
        win = '{valid: 1'b0, src: 5'h00, lvl: 2'h0};
        for (int i = PIC_NSRC - 1; i >= 0; i--) begin
            logic [1:0] l;
            l = sw_level(swp_ff, i);
            if (mreq_ff[i] && src_enable[i] && l > cur_lvl &&
                (!win.valid || l >= win.lvl)) begin
                win = '{valid: 1'b1, src: 5'(i + PIC_SRC_MASK0), lvl: l};
            end
        end
        // top pin is maskable only by level 3 itself; it may preempt a trap
        if (tli_pend_ff && (cur_lvl != PIC_LVL_TOP || in_trap_ff)) begin
            win = '{valid: 1'b1, src: PIC_SRC_TLI, lvl: PIC_LVL_TOP};
        end
        if (trap_pend_ff && !in_trap_ff) begin
            win = '{valid: 1'b1, src: PIC_SRC_TRAP, lvl: PIC_LVL_TOP};
        end
        if (rst_pend_ff) begin
            win = '{valid: 1'b1, src: PIC_SRC_RESET, lvl: PIC_LVL_TOP};
        end
    end

    // entry sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            PIC_IDLE, PIC_RUN: begin
                if (take) begin
                    nxt_state = (win.src == PIC_SRC_RESET) ? PIC_VECT
                                                           : PIC_STACK;
                end
            end
            PIC_STACK: begin
                if (stack_cnt_ff == PIC_STACK_BYTES - 3'h1) begin
                    nxt_state = PIC_VECT;
                end
            end
            PIC_VECT: nxt_state = PIC_RUN;
            default: nxt_state = PIC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= PIC_IDLE;
            win_ff <= '{valid: 1'b0, src: 5'h00, lvl: 2'h0};
            stack_cnt_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            if (take) begin
                win_ff <= win;
            end
            stack_cnt_ff <= (state_ff == PIC_STACK) ? stack_cnt_ff + 3'h1
                                                    : 3'h0;
        end
    end

    // trap routine tracking, ended by return or preemption by top pin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            in_trap_ff <= 1'b0;
        end else if (entry) begin
            in_trap_ff <= (win_ff.src == PIC_SRC_TRAP);
        end else if (iret_exec) begin
            in_trap_ff <= 1'b0;
        end
    end

    // condition code update: raise on entry, restore on return
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cc_out_ff <= PIC_CC_RESET;
            cc_load_ff <= 1'b0;
        end else if (entry) begin
            cc_out_ff <= cc_in | PIC_CC_RESET;
            cc_load_ff <= 1'b1;
        end else if (iret_exec) begin
            cc_out_ff <= stacked_cc;
            cc_load_ff <= 1'b1;
        end else begin
            cc_load_ff <= 1'b0;
        end
    end

    assign stack_push = (state_ff == PIC_STACK);
    assign stack_index = stack_cnt_ff;
    assign vector_load = entry;
    assign vector_src = win_ff.src;
    assign cc_out = cc_out_ff;
    assign cc_load = cc_load_ff;
    // only non-maskable, top pin or enabled external/peripheral requests wake halt
    assign wake = core_halted && (rst_pend_ff || trap_pend_ff ||
                  tli_pend_ff || |(mreq_ff & src_enable));
    assign pending = {mreq_ff, tli_pend_ff, trap_pend_ff, rst_pend_ff};
endmodule : pic_interrupt_arbiter
`default_nettype wire

// ===== sim/pic_arb_chk.sv
// port checker for the interrupt arbiter
`default_nettype none
module pic_arb_chk
    import pic_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // source side
    input wire logic trap_exec,
    input wire logic [PIC_NSRC-1:4] periph_req,
    input wire logic [PIC_NSRC-1:4] periph_clear,
    // core side
    input wire logic core_halted,
    input wire logic iret_exec,
    input wire logic [7:0] stacked_cc,
    input wire logic [7:0] cc_in,
    input wire logic wake,
    input wire logic stack_push,
    input wire logic [2:0] stack_index,
    input wire logic vector_load,
    input wire logic [4:0] vector_src,
    input wire logic [7:0] cc_out,
    input wire logic cc_load,
    input wire logic [PIC_NSRC+2:0] pending
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_rst;
        $fell(sys_rst) |-> ##[1:2] vector_load && vector_src == PIC_SRC_RESET;
    endproperty
    a_rst: assert property (p_rst) else $error("no reset entry");
    property p_stk;
        $rose(stack_push) |-> stack_push[*5] ##1 vector_load;
    endproperty
    a_stk: assert property (p_stk) else $error("bad stacking");
    property p_idx;
        $rose(stack_push) |-> stack_index == 3'h0 ##4 stack_index == 3'h4;
    endproperty
    a_idx: assert property (p_idx) else $error("bad stack order");
    property p_cc;
        vector_load |=> cc_load && cc_out == ($past(cc_in) | 8'h28);
    endproperty
    a_cc: assert property (p_cc) else $error("mask not raised");
    property p_ret;
        iret_exec |=> cc_load && cc_out == $past(stacked_cc);
    endproperty
    a_ret: assert property (p_ret) else $error("cc not restored");
    property p_wake; core_halted && pending[1:0] != 2'b00 |-> wake; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_trap; trap_exec |=> pending[1]; endproperty
    a_trap: assert property (p_trap) else $error("trap not latched");
    property p_clr;
        periph_clear[8] && !periph_req[8] |=> !pending[11];
    endproperty
    a_clr: assert property (p_clr) else $error("latch kept");
    property p_ext;
        vector_load && vector_src == 5'h04 |=> !pending[4];
    endproperty
    a_ext: assert property (p_ext) else $error("edge latch kept");
    c_trap: cover property (vector_load && vector_src == PIC_SRC_TRAP);
    c_tli: cover property (vector_load && vector_src == PIC_SRC_TLI);
    c_ret: cover property (iret_exec ##1 cc_load);
endmodule : pic_arb_chk
bind pic_interrupt_arbiter pic_arb_chk u_chk (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .trap_exec(trap_exec), .periph_req(periph_req),
    .periph_clear(periph_clear), .core_halted(core_halted),
    .iret_exec(iret_exec), .stacked_cc(stacked_cc), .cc_in(cc_in),
    .wake(wake), .stack_push(stack_push), .stack_index(stack_index),
    .vector_load(vector_load), .vector_src(vector_src), .cc_out(cc_out),
    .cc_load(cc_load), .pending(pending));
`default_nettype wire

// ===== sim/pic_core_model.sv
// behavioural core: condition code and a stack of saved cc values
`default_nettype none
module pic_core_model
    import pic_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // arbiter side
    input wire logic stack_push,
    input wire logic [2:0] stack_index,
    input wire logic cc_load,
    input wire logic [7:0] cc_out,
    input wire logic iret_exec,
    output logic [7:0] cc_in,
    output logic [7:0] stacked_cc
);
    logic [7:0] cc_ff;
    logic [7:0] stk_ff [0:7];
    logic [2:0] sp_ff;
    // bottom entry is the level the reset routine drops to on return
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sp_ff <= 3'h1;
            stk_ff[0] <= 8'h00;
        end else if (stack_push && stack_index == 3'h4) begin
            stk_ff[sp_ff] <= cc_ff;
            sp_ff <= sp_ff + 3'h1;
        end else if (iret_exec && sp_ff > 3'h1) begin
            sp_ff <= sp_ff - 3'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        cc_ff <= sys_rst ? PIC_CC_RESET : (cc_load ? cc_out : cc_ff);
    end
    assign cc_in = cc_ff;
    assign stacked_cc = stk_ff[sp_ff-3'h1];
endmodule : pic_core_model
`default_nettype wire

// ===== sim/tb.sv
// testbench: registers, entry sequence, priority, masking and nesting
`default_nettype none
module tb
    import pic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic trap_exec = 1'b0, tli_pin = 1'b0, halt = 1'b0, iret = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, cc_in, scc;
    logic [3:0] ext_pin = 4'hf;
    logic [PIC_NSRC-1:4] preq = '0, pclr = '0;
    logic [PIC_NSRC-1:0] src_en = '1;
    logic wake, push, vload, cc_load;
    logic [2:0] sidx;
    logic [4:0] vsrc;
    logic [7:0] cc_out;
    logic [PIC_NSRC+2:0] pending;
    logic [7:0] ccq [$] = '{8'h00};
    int num_errors = 0, compares = 0, cyc = 0;
    pic_interrupt_arbiter dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .trap_exec(trap_exec),
        .tli_pin(tli_pin), .ext_pin(ext_pin), .periph_req(preq),
        .periph_clear(pclr), .src_enable(src_en), .core_halted(halt),
        .iret_exec(iret), .stacked_cc(scc), .cc_in(cc_in), .wake(wake),
        .stack_push(push), .stack_index(sidx), .vector_load(vload),
        .vector_src(vsrc), .cc_out(cc_out), .cc_load(cc_load),
        .pending(pending));
    pic_core_model u_core (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .stack_push(push), .stack_index(sidx), .cc_load(cc_load),
        .cc_out(cc_out), .iret_exec(iret), .cc_in(cc_in), .stacked_cc(scc));
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic [7:0] a, d, input logic w,
                       input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        if (!w) check("reg_rdata", rdata, exp);
    endtask : bus
    task automatic pulse(input logic [PIC_NSRC-1:4] m, input logic clr);
        @(posedge ref_clk);
        pclr <= clr ? m : '0;
        preq <= clr ? '0 : m;
        @(posedge ref_clk);
        pclr <= '0;
        preq <= '0;
    endtask : pulse
    // waits for an entry and judges stacking, mask raise and latch clear
    task automatic ent(input logic [4:0] src, input int nstk);
        logic [7:0] c;
        int n;
        n = 0;
        for (int i = 0; i < 80 && vload !== 1'b1; i++) begin
            @(negedge ref_clk);
            n += (push === 1'b1);
        end
        c = cc_in;
        check("vector_src", 8'(vsrc), 8'(src));
        check("stack_cycles", 8'(n), 8'(nstk));
        @(negedge ref_clk);
        check("cc_out", cc_out, c | 8'h28);
        check("entry_latch", 8'(pending[src]), 8'h00);
        if (src != PIC_SRC_RESET) ccq.push_back(c);
    endtask : ent
    task automatic ret();
        logic [7:0] e;
        e = ccq.size() > 1 ? ccq.pop_back() : ccq[0];
        @(posedge ref_clk);
        iret <= 1'b1;
        @(posedge ref_clk);
        iret <= 1'b0;
        @(negedge ref_clk);
        check("iret_cc", cc_out, e);
    endtask : ret
    task automatic quiet(input int idx);
        int v;
        v = 0;
        repeat (20) begin
            @(negedge ref_clk);
            v += (vload === 1'b1);
        end
        check("unserved", 8'(v), 8'h00);
        check("still_pending", 8'(pending[idx]), 8'h01);
    endtask : quiet
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        ent(PIC_SRC_RESET, 0);
        for (int i = 0; i < 6; i++)
            bus(PIC_OFF_SWP0 + 8'(i), 8'h00, 1'b0, i < 4 ? 8'hff : 8'h00);
        bus(PIC_OFF_SWP1, 8'ha9, 1'b1, 8'h00);
        bus(PIC_OFF_SWP2, 8'hfc, 1'b1, 8'h00);
        bus(PIC_OFF_EIC0, 8'h55, 1'b1, 8'h00);
        bus(PIC_OFF_EIC1, 8'h55, 1'b1, 8'h00);
        bus(8'h2b, 8'h5a, 1'b1, 8'h00);
        bus(PIC_OFF_SWP1, 8'h00, 1'b0, 8'ha9);
        bus(PIC_OFF_EIC1, 8'h00, 1'b0, 8'h55);
        bus(8'h2b, 8'h00, 1'b0, 8'h00);
        ret();
        $display("test boot done");
        pulse(12'h003, 1'b0);
        ent(5'h08, 5);
        ret();
        ent(5'h07, 5);
        ret();
        pulse(12'h00c, 1'b0);
        ent(5'h09, 5);
        ret();
        ent(5'h0a, 5);
        ret();
        $display("test priority done");
        pulse(12'h010, 1'b0);
        quiet(11);
        pulse(12'h010, 1'b1);
        @(negedge ref_clk);
        check("cleared_latch", 8'(pending[11]), 8'h00);
        @(posedge ref_clk);
        src_en[9] <= 1'b0;
        pulse(12'h020, 1'b0);
        quiet(12);
        pulse(12'h020, 1'b1);
        @(posedge ref_clk);
        src_en[9] <= 1'b1;
        $display("test masking done");
        pulse(12'h002, 1'b0);
        ent(5'h08, 5);
        @(posedge ref_clk);
        halt <= 1'b1;
        trap_exec <= 1'b1;
        @(posedge ref_clk);
        trap_exec <= 1'b0;
        @(negedge ref_clk);
        check("wake", 8'(wake), 8'h01);
        ent(PIC_SRC_TRAP, 5);
        check("idle_wake", 8'(wake), 8'h00);
        @(posedge ref_clk);
        halt <= 1'b0;
        tli_pin <= 1'b1;
        ent(PIC_SRC_TLI, 5);
        ret();
        ret();
        ret();
        $display("test nesting done");
        @(posedge ref_clk);
        tli_pin <= 1'b0;
        ext_pin[1] <= 1'b0;
        repeat (6) @(posedge ref_clk);
        ext_pin[1] <= 1'b1;
        ent(5'h04, 5);
        ret();
        // pin 0 moved to falling edge sensitivity
        bus(PIC_OFF_EIC0, 8'h56, 1'b1, 8'h00);
        @(posedge ref_clk);
        ext_pin[0] <= 1'b0;
        ent(PIC_SRC_MASK0, 5);
        ret();
        $display("test external done");
        complete_run();
    end
endmodule : tb
`default_nettype wire
